/* verilog/rst_seq_pkg.sv */
// Purpose: Shared constants and types for the reset source sequencer
// Assumes: core_clk runs at 10 MHz
// Notes:   Times are kept in their own unit; cycle counts derive from them
package rst_seq_pkg;

    // ************************************************************
    // Clock and minimum pulse times
    // ************************************************************
    localparam int CLK_PERIOD_NS     = 100;
    localparam int EXT_MIN_LOW_NS    = 500;
    localparam int BOD_MIN_LOW_NS    = 2000;
    // Least times round up to whole cycles
    localparam int EXT_MIN_LOW_CYC   = (EXT_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOD_MIN_LOW_CYC   = (BOD_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Start-up delay
    // ************************************************************
    localparam int RT_SHORT_CYC      = 4096;
    localparam int RT_LONG_CYC       = 65536;
    localparam int CLK_PART_CYC      = 6;
    localparam int CNT_W             = 17;
    localparam int LONG_SEL_BIT      = 0;

    // ************************************************************
    // Fuses, vector and cause flags
    // ************************************************************
    localparam logic        FUSE_PROGRAMMED = 1'b0;
    localparam logic [11:0] RESET_VECTOR    = 12'h000;
    localparam int          CAUSE_W         = 4;
    localparam int          CAUSE_POR       = 0;
    localparam int          CAUSE_EXT       = 1;
    localparam int          CAUSE_WDT       = 2;
    localparam int          CAUSE_BOD       = 3;

    // Gray order along hold, real-time, clocks, run
    typedef enum logic [1:0] {
        ST_HOLD     = 2'b00,
        ST_REALTIME = 2'b01,
        ST_CLOCKS   = 2'b11,
        ST_RUN      = 2'b10
    } delay_state_t;

endpackage

/* verilog/delay_if.sv */
// Purpose: Link between the reset combiner and the start-up delay timer
// Assumes: One clock domain
// Notes:   ctrl drives the requests, timer answers with done and stable
`timescale 1ns/10ps
`default_nettype none
interface delay_if;
    logic hold;     // Any reset cause active
    logic wake;     // Wake from power-down, one cycle
    logic long_sel; // Long real-time portion selected
    logic osc_tick; // One watchdog oscillator cycle
    logic done;     // Core may leave reset
    logic stable;   // Full start-up finished, clocks stable

    modport ctrl  (output hold, output wake, output long_sel, output osc_tick,
                   input done, input stable);
    modport timer (input hold, input wake, input long_sel, input osc_tick,
                   output done, output stable);
endinterface
`default_nettype wire

/* verilog/min_low_filter.sv */
// Purpose: Qualifies an active level only after it lasts LEN cycles
// Assumes: Input synchronous to core_clk
// Notes:   Release is immediate; shorter pulses are dropped
`timescale 1ns/10ps
`default_nettype none
module min_low_filter #(
    parameter int LEN = 5
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Level in and qualified level out
    input  wire logic active,
    output var  logic qualified
);
    import rst_seq_pkg::*;

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    if (LEN < 1) begin : g_len_check
        $error("min_low_filter needs LEN of at least one");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          q;
    } filt_state_t;

    filt_state_t s_reg;
    filt_state_t s_next;

    // Count consecutive active cycles, saturating at LEN
    always_comb begin
        s_next = s_reg;
        if (!active) begin
            s_next.cnt = '0;
            s_next.q   = 1'b0;
        end else if (s_reg.cnt != LEN_C) begin
            s_next.cnt = s_reg.cnt + CW'(1);
            s_next.q   = (s_reg.cnt + CW'(1)) == LEN_C;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign qualified = s_reg.q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_filter_min_len: assert property ($rose(s_reg.q) |-> $past(active, 1) && s_reg.cnt == LEN_C)
        else $error("qualified rose before the minimum active length");
endmodule
`default_nettype wire

/* verilog/startup_delay_timer.sv */
// Purpose: Start-up delay, real-time part on watchdog ticks then clock part
// Assumes: osc_tick is a one-cycle pulse per watchdog oscillator cycle
// Notes:   Any hold restarts the whole delay from zero
`timescale 1ns/10ps
`default_nettype none
module startup_delay_timer #(
    parameter int RT_LONG = rst_seq_pkg::RT_LONG_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Link to the combiner
    delay_if.timer    dif
);
    import rst_seq_pkg::*;

    if (RT_LONG < 1 || RT_LONG > (1 << CNT_W) || RT_SHORT_CYC > (1 << CNT_W)) begin : g_chk
        $error("startup_delay_timer counts out of range");
    end

    typedef struct packed {
        delay_state_t     st;
        logic [CNT_W-1:0] cnt;
        logic             wake_mode;
        logic             done;
        logic             stable;
    } tmr_state_t;

    tmr_state_t s_reg;
    tmr_state_t s_next;
    logic [CNT_W-1:0] rt_last;

    // Last count of the real-time portion, by fuse selection
    assign rt_last = dif.long_sel ? CNT_W'(RT_LONG - 1) : CNT_W'(RT_SHORT_CYC - 1);

    always_comb begin
        s_next = s_reg;
        if (dif.hold) begin
            s_next.st        = ST_HOLD;
            s_next.cnt       = '0;
            s_next.wake_mode = 1'b0;
        end else begin
            unique case (s_reg.st)
                ST_HOLD: begin
                    s_next.st  = ST_REALTIME;
                    s_next.cnt = '0;
                end
                ST_REALTIME: begin
                    if (dif.osc_tick) begin
                        if (s_reg.cnt == rt_last) begin
                            s_next.st  = ST_CLOCKS;
                            s_next.cnt = '0;
                        end else begin
                            s_next.cnt = s_reg.cnt + CNT_W'(1);
                        end
                    end
                end
                ST_CLOCKS: begin
                    if (s_reg.cnt == CNT_W'(CLK_PART_CYC - 1)) begin
                        s_next.st        = ST_RUN;
                        s_next.cnt       = '0;
                        s_next.wake_mode = 1'b0;
                    end else begin
                        s_next.cnt = s_reg.cnt + CNT_W'(1);
                    end
                end
                ST_RUN: begin
                    if (dif.wake) begin
                        s_next.st        = ST_CLOCKS;
                        s_next.cnt       = '0;
                        s_next.wake_mode = 1'b1;
                    end
                end
            endcase
        end
        // Wake keeps the core out of reset; only stable drops
        s_next.done   = (s_next.st == ST_RUN) || s_next.wake_mode;
        s_next.stable = (s_next.st == ST_RUN);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '{st: ST_HOLD, cnt: '0, wake_mode: 1'b0, done: 1'b0, stable: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign dif.done   = s_reg.done;
    assign dif.stable = s_reg.stable;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_hold_restarts: assert property (dif.hold |=> s_reg.st == ST_HOLD && s_reg.cnt == '0)
        else $error("hold did not restart the delay");
    chk_rt_osc_only: assert property (s_reg.st == ST_REALTIME && !dif.osc_tick && !dif.hold
                                      |=> $stable(s_reg.cnt))
        else $error("real-time count moved without an oscillator tick");
    chk_wake_skip_rt: assert property (s_reg.st == ST_RUN && dif.wake && !dif.hold
                                       |=> s_reg.st == ST_CLOCKS && s_reg.done ##6 s_reg.st == ST_RUN)
        else $error("wake did not use only the clock part");
    cov_wake: cover property (s_reg.st == ST_RUN && dif.wake);
endmodule
`default_nettype wire

/* verilog/reset_source_sequencer.sv */
// Purpose: Gathers reset causes and sequences the core reset release
// Assumes: All inputs synchronous to core_clk; detectors flag low supply high
// Notes:   Fuses read 1 when unprogrammed; pin reset needs core_clk running
`timescale 1ns/10ps
`default_nettype none
module reset_source_sequencer #(
    parameter int RT_LONG = rst_seq_pkg::RT_LONG_CYC
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // Supply monitors
    input  wire logic                        por_low,
    input  wire logic                        brownout_low,
    // External reset pin, active low
    input  wire logic                        reset_pin_n,
    // Watchdog
    input  wire logic                        wdt_enable,
    input  wire logic                        wdt_timeout,
    input  wire logic                        wdt_osc_tick,
    // Fuses
    input  wire logic                        reset_pin_disable_fuse,
    input  wire logic                        brownout_enable_fuse,
    input  wire logic                        brownout_level_fuse,
    input  wire logic [3:0]                  clock_select_fuses,
    // Power management
    input  wire logic                        wake_from_powerdown,
    // Cause status
    input  wire logic                        cause_clear,
    output var  logic [rst_seq_pkg::CAUSE_W-1:0] reset_cause,
    // Core side
    output var  logic                        core_reset,
    output var  logic                        clocks_stable,
    output var  logic [11:0]                 reset_vector,
    output var  logic                        pin_gpio_mode,
    output var  logic                        brownout_level_high
);
    import rst_seq_pkg::*;

    if (RT_LONG < RT_SHORT_CYC || RT_LONG > (1 << CNT_W)) begin : g_param_check
        $error("RT_LONG outside the range the delay counter serves");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic               wdt_req_d;
        logic               wdt_pulse;
        logic               core_reset;
        logic               stable;
        logic [CAUSE_W-1:0] cause;
        logic [11:0]        vector;
        logic               gpio_mode;
        logic               level_high;
    } seq_state_t;

    seq_state_t s_reg;
    seq_state_t s_next;

    logic ext_active;
    logic ext_q;
    logic bod_active;
    logic bod_q;
    logic wdt_req;
    logic hold;

    delay_if dif ();

    // ************************************************************
    // Source qualification
    // ************************************************************
    // Pin only counts as reset while the disable fuse is unprogrammed
    assign ext_active = (reset_pin_disable_fuse != FUSE_PROGRAMMED) && !reset_pin_n;

    // Brown-out detector only counts while its enable fuse is programmed
    assign bod_active = (brownout_enable_fuse == FUSE_PROGRAMMED) && brownout_low;

    assign wdt_req = wdt_enable && wdt_timeout;

    // Short pin glitches are dropped; a clocked filter cannot act without a clock
    min_low_filter #(
        .LEN       (EXT_MIN_LOW_CYC)
    ) u_ext_filter (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .active    (ext_active),
        .qualified (ext_q)
    );

    // Supply dips shorter than the minimum period are not a brown-out
    min_low_filter #(
        .LEN       (BOD_MIN_LOW_CYC)
    ) u_bod_filter (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .active    (bod_active),
        .qualified (bod_q)
    );

    // ************************************************************
    // Combined cause and start-up delay
    // ************************************************************
    // Power-on goes in unfiltered so a supply drop acts at once
    assign hold = por_low || ext_q || s_reg.wdt_pulse || bod_q;

    assign dif.hold     = hold;
    assign dif.wake     = wake_from_powerdown;
    assign dif.long_sel = clock_select_fuses[LONG_SEL_BIT];
    assign dif.osc_tick = wdt_osc_tick;

    startup_delay_timer #(
        .RT_LONG  (RT_LONG)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dif      (dif)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        // One-cycle watchdog pulse on each new time-out request
        s_next.wdt_req_d = wdt_req;
        s_next.wdt_pulse = wdt_req && !s_reg.wdt_req_d;
        // Release only after the delay, and only on a clock edge
        s_next.core_reset = hold || !dif.done;
        s_next.stable     = dif.stable && !hold;
        // Sticky causes; a new cause wins over a clear in the same cycle
        if (cause_clear) begin
            s_next.cause = '0;
        end
        s_next.cause[CAUSE_POR] = s_next.cause[CAUSE_POR] | por_low;
        s_next.cause[CAUSE_EXT] = s_next.cause[CAUSE_EXT] | ext_q;
        s_next.cause[CAUSE_WDT] = s_next.cause[CAUSE_WDT] | s_reg.wdt_pulse;
        s_next.cause[CAUSE_BOD] = s_next.cause[CAUSE_BOD] | bod_q;
        // Fetch restarts at the reset vector after every release
        s_next.vector     = RESET_VECTOR;
        s_next.gpio_mode  = (reset_pin_disable_fuse == FUSE_PROGRAMMED);
        // High level select steers the analog detector to the 4.0 V trip
        s_next.level_high = (brownout_level_fuse == FUSE_PROGRAMMED);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset holds the core in reset and shows no causes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '{wdt_req_d: 1'b0, wdt_pulse: 1'b0, core_reset: 1'b1, stable: 1'b0,
                       cause: '0, vector: RESET_VECTOR, gpio_mode: 1'b0, level_high: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign core_reset          = s_reg.core_reset;
    assign clocks_stable       = s_reg.stable;
    assign reset_cause         = s_reg.cause;
    assign reset_vector        = s_reg.vector;
    assign pin_gpio_mode       = s_reg.gpio_mode;
    assign brownout_level_high = s_reg.level_high;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_por_immediate: assert property (por_low |=> core_reset)
        else $error("power-on low did not reset at once");
    chk_any_cause: assert property (hold |=> core_reset ##1 core_reset)
        else $error("active cause did not hold the core in reset");
    chk_release_gated: assert property ($fell(core_reset) |-> $past(dif.done) && !$past(hold))
        else $error("core left reset before the delay expired");
    chk_pin_fuse_gate: assert property (reset_pin_disable_fuse == FUSE_PROGRAMMED |-> !ext_active)
        else $error("pin reset active while disabled by fuse");
    chk_ext_resets: assert property ((!reset_pin_n && reset_pin_disable_fuse != FUSE_PROGRAMMED)
                                     [*6] |=> core_reset)
        else $error("long pin low did not reset");
    chk_wdt_one_cycle: assert property ($rose(wdt_req) |=> s_reg.wdt_pulse ##1 !s_reg.wdt_pulse)
        else $error("watchdog pulse not exactly one cycle");
    chk_wdt_disabled: assert property (!wdt_enable |=> !s_reg.wdt_pulse)
        else $error("watchdog reset while disabled");
    chk_bod_gate: assert property (brownout_enable_fuse != FUSE_PROGRAMMED |-> !bod_active)
        else $error("brown-out active while disabled by fuse");
    chk_bod_short: assert property ($rose(bod_active) ##1 !bod_active |-> !bod_q)
        else $error("short supply dip taken as brown-out");
    chk_wdt_delay: assert property ($fell(s_reg.wdt_pulse) && !hold |-> core_reset ##1 core_reset)
        else $error("watchdog release skipped the delay");
    chk_vector_zero: assert property ($fell(core_reset) |-> reset_vector == RESET_VECTOR)
        else $error("fetch address not zero at release");

    cov_por_release: cover property ($fell(core_reset) && reset_cause[CAUSE_POR]);
    cov_wdt_reset: cover property (s_reg.wdt_pulse ##[1:200] !core_reset);
    cov_bod_reset: cover property (bod_q ##1 core_reset);
endmodule
`default_nettype wire

/* testbench/supply_pin_model.sv */
// Purpose: Far side of the sequencer: supply monitors, reset pin, watchdog oscillator
// Assumes: Bench sets the commands at the falling edge of core_clk
// Notes:   Oscillator runs free; tick_div sets its period in core_clk cycles
`timescale 1ns/10ps
`default_nettype none
module supply_pin_model (
    // Clock
    input  wire logic       core_clk,
    // Commands from the bench
    input  wire logic       por_cmd,
    input  wire logic       bod_cmd,
    input  wire logic       pin_cmd,
    input  wire logic [1:0] tick_div,
    // Lines into the sequencer
    output var  logic       por_low,
    output var  logic       brownout_low,
    output var  logic       reset_pin_n,
    output var  logic       wdt_osc_tick
);
    logic [1:0] tick_cnt = 2'h0;

    // Detectors flag low supply high; pin has a pull-up, so released reads high
    assign por_low      = por_cmd;
    assign brownout_low = bod_cmd;
    assign reset_pin_n  = ~pin_cmd;

    // One tick per oscillator cycle; a slow setting stretches the real-time part
    initial wdt_osc_tick = 1'b0;
    always @(negedge core_clk) begin
        tick_cnt     <= (tick_cnt >= tick_div - 2'h1) ? 2'h0 : tick_cnt + 2'h1;
        wdt_osc_tick <= (tick_cnt == 2'h0);
    end
endmodule
`default_nettype wire

/* testbench/reset_source_sequencer_tb.sv */
// Purpose: Self-checking bench for the reset source sequencer
// Assumes: Long real-time part shrunk to 8192 ticks; oscillator tick every 2 cycles
// Notes:   Release windows allow up to 30 cycles of pipeline past the exact count
`timescale 1ns/10ps
`default_nettype none
module reset_source_sequencer_tb;
    import rst_seq_pkg::*;
    localparam int RT_SIM = 8192;
    logic        core_clk, rst_n, por_cmd, bod_cmd, pin_cmd, wdt_enable, wdt_timeout;
    logic        rp_dis, bod_en, bod_lvl, wake, cause_clear, core_reset, clocks_stable;
    logic        pin_gpio_mode, brownout_level_high, hit;
    logic [1:0]  tick_div;
    logic [3:0]  cks, reset_cause;
    logic [11:0] reset_vector;
    wire logic   por_low, brownout_low, reset_pin_n, wdt_osc_tick;
    int          failures, samples_checked;

    // ************************************************************
    // Design and far side
    // ************************************************************
    reset_source_sequencer #(.RT_LONG(RT_SIM)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .por_low(por_low), .brownout_low(brownout_low), .reset_pin_n(reset_pin_n),
        .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout), .wdt_osc_tick(wdt_osc_tick),
        .reset_pin_disable_fuse(rp_dis), .brownout_enable_fuse(bod_en),
        .brownout_level_fuse(bod_lvl), .clock_select_fuses(cks),
        .wake_from_powerdown(wake), .cause_clear(cause_clear), .reset_cause(reset_cause),
        .core_reset(core_reset), .clocks_stable(clocks_stable), .reset_vector(reset_vector),
        .pin_gpio_mode(pin_gpio_mode), .brownout_level_high(brownout_level_high));
    supply_pin_model far (.core_clk(core_clk), .por_cmd(por_cmd), .bod_cmd(bod_cmd),
        .pin_cmd(pin_cmd), .tick_div(tick_div), .por_low(por_low),
        .brownout_low(brownout_low), .reset_pin_n(reset_pin_n), .wdt_osc_tick(wdt_osc_tick));

    // 10 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Runs n cycles and notes whether core reset showed up meanwhile
    task automatic run(int n);
        hit = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            hit = hit | (core_reset === 1'b1);
        end
    endtask

    // Counts cycles until core reset drops; a hang ends the run
    task automatic wait_release(int lo, string what);
        int n;
        n = 0;
        while (core_reset === 1'b1 && n < lo + 40) begin
            @(negedge core_clk);
            n++;
        end
        check(what, 17'(n >= lo && n <= lo + 30), 17'h1);
        if (n >= lo + 40) print_verdict();
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic cold_start;
        run(10);
        check("vector", 17'(reset_vector), 17'h0);
        check("cause por", 17'(reset_cause[0]), 17'h1);
        check("gpio mode", 17'(pin_gpio_mode), 17'h0);
        check("bod level", 17'(brownout_level_high), 17'h0);
        por_cmd = 1'b0;
        wait_release(2 * 4096, "por delay");
        check("stable", 17'(clocks_stable), 17'h1);
    endtask

    task automatic por_restart;
        por_cmd = 1'b1;
        run(2);
        check("por at once", 17'(core_reset), 17'h1);
        por_cmd = 1'b0;
        run(1000);
        por_cmd = 1'b1;
        run(4);
        por_cmd = 1'b0;
        wait_release(2 * 4096, "restart delay");
    endtask

    task automatic pin_cases;
        rp_dis = 1'b0;
        pin_cmd = 1'b1;
        run(12);
        check("pin as gpio", 17'({pin_gpio_mode, hit}), 17'h2);
        rp_dis = 1'b1;
        cause_clear = 1'b1;
        pin_cmd = 1'b1;
        run(3);
        cause_clear = 1'b0;
        pin_cmd = 1'b0;
        run(6);
        check("short pin", 17'({hit, reset_cause}), 17'h0);
        pin_cmd = 1'b1;
        run(10);
        check("long pin", 17'({hit, reset_cause[1]}), 17'h3);
        pin_cmd = 1'b0;
        wait_release(2 * 4096, "pin delay");
    endtask

    task automatic bod_cases;
        bod_cmd = 1'b1;
        run(40);
        check("bod off", 17'(hit), 17'h0);
        bod_en = 1'b0;
        bod_lvl = 1'b0;
        bod_cmd = 1'b1;
        run(10);
        bod_cmd = 1'b0;
        run(4);
        check("bod dip", 17'({hit, brownout_level_high}), 17'h1);
        bod_cmd = 1'b1;
        run(30);
        check("bod on", 17'({hit, reset_cause[3]}), 17'h3);
        bod_cmd = 1'b0;
        wait_release(2 * 4096, "bod delay");
    endtask

    task automatic wdt_cases;
        wdt_timeout = 1'b1;
        run(5);
        check("wdt off", 17'(hit), 17'h0);
        wdt_enable = 1'b1;
        wdt_timeout = 1'b1;
        run(4);
        wdt_timeout = 1'b0;
        check("wdt on", 17'({hit, reset_cause[2]}), 17'h3);
        wait_release(2 * 4096 - 4, "wdt delay");
        wdt_enable = 1'b0;
    endtask

    task automatic wake_case;
        int n;
        wake = 1'b1;
        run(1);
        wake = 1'b0;
        run(1);
        check("wake drop", 17'({clocks_stable, hit}), 17'h0);
        n = 1;
        while (clocks_stable !== 1'b1 && n < 20) begin
            run(1);
            n++;
        end
        check("wake clocks only", 17'(n >= 6 && n <= 9), 17'h1);
    endtask

    task automatic long_and_slow;
        cks = 4'h1;
        por_cmd = 1'b1;
        run(3);
        por_cmd = 1'b0;
        wait_release(2 * RT_SIM, "long delay");
        cks = 4'h0;
        tick_div = 2'h3;
        por_cmd = 1'b1;
        run(3);
        por_cmd = 1'b0;
        wait_release(3 * 4096, "slow osc");
        tick_div = 2'h2;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rst_n, bod_cmd, pin_cmd, wdt_enable, wdt_timeout, wake, cause_clear} = '0;
        {por_cmd, rp_dis, bod_en, bod_lvl} = 4'hF;
        {failures, samples_checked} = '0;
        tick_div = 2'h2;
        cks = 4'h0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        cold_start();
        por_restart();
        pin_cases();
        bod_cases();
        wdt_cases();
        wake_case();
        long_and_slow();
        print_verdict();
    end
endmodule
`default_nettype wire
